// ### common/canopen_emcy_defs.svh
`ifndef CANOPEN_EMCY_DEFS_SVH
`define CANOPEN_EMCY_DEFS_SVH
// Notes on behaviour
// - emergency payload: code, errreg, node, reply data
// - emergency id 0001 plus node 1..127
// - alarm, target and capture classes gated by enable bit
// - alarm change sends frame, errreg 01
// - alarm number maps to fixed error code
// - alarm reset command gives code 0000
// - target 0xff05, capture 0xff06, errreg 00
// - data holds reached or captured position
// - target reached after tolerance dwell window
// - enabled target detection owns window settings
// - user request sends 0xff09 with payload
// - user request bit cleared after sending
// - guarding request sets receipt flag
// - nmt state machine with boot-up message
// - communication objects are read only
// - parameter and plc areas read/write
// - set-bit and clear-bit parameter indexes
// - cam table parts at 0x2004, 0x2005
// - sub-index 0 count, n+1 parameter n
// - long write updates next, read four bytes

`define CLK_PERIOD_NS     20
`define DWELL_TICK_NS     2048000
`define DWELL_TICK_CYCLES (`DWELL_TICK_NS / `CLK_PERIOD_NS)
`define PARAM_COUNT       255
`define EMCY_CLASSES      4
`define CLS_ALARM         2'h0
`define CLS_TARGET        2'h1
`define CLS_CAPTURE       2'h2
`define CLS_USER          2'h3

`define FUNC_NMT          4'h0
`define FUNC_EMCY         4'h1
`define FUNC_SDO_TX       4'hb
`define FUNC_SDO_RX       4'hc
`define FUNC_GUARD        4'he
`define NMT_START         8'h01
`define NMT_STOP          8'h02
`define NMT_PREOP         8'h80
`define NMT_RESET_NODE    8'h81
`define NMT_RESET_COMM    8'h82
`define GUARD_STOPPED     7'h04
`define GUARD_OPER        7'h05
`define GUARD_PREOP       7'h7f
`define EMCY_LEN          4'h8
`define BOOT_LEN          4'h1

`define ERRREG_ALARM      8'h01
`define ERRREG_NONE       8'h00
`define CODE_NONE         16'h0000
`define CODE_OVERVOLTAGE  16'h3210
`define CODE_UNDERVOLTAGE 16'h3220
`define CODE_OVERCURRENT  16'h2340
`define CODE_ENCODER      16'h7303
`define CODE_MOTOR_TEMP   16'h4110
`define CODE_DRIVE_TEMP   16'h4310
`define CODE_AUX_ONE      16'hff00
`define CODE_AUX_TWO      16'hff01
`define CODE_CHECKSUM     16'h6310
`define CODE_DEFAULTS     16'h6320
`define CODE_GENERIC      16'h1000
`define CODE_TARGET       16'hff05
`define CODE_CAPTURE      16'hff06
`define CODE_USER         16'hff09

`define OVERVOLTAGE_ALARM        8'h01
`define UNDERVOLTAGE_ALARM       8'h02
`define OVERCURRENT_ALARM        8'h03
`define ENCODER_BREAK_ALARM      8'h04
`define MOTOR_OVERTEMP_ALARM     8'h05
`define DRIVE_OVERTEMP_ALARM     8'h06
`define AUX_TRIP_ONE_ALARM       8'h07
`define AUX_TRIP_TWO_ALARM       8'h08
`define PROGRAM_CHECKSUM_ALARM   8'h0a
`define PARAMETER_CHECKSUM_ALARM 8'h0b
`define DEFAULTS_LOADED_ALARM    8'h0f

`define MODE_STEP_TARGET  8'h0d
`define MODE_REQ_TARGET   8'h0e
`define PIDX_GUARD        8'h27
`define PIDX_CONTROL      8'h46
`define PIDX_TOLERANCE    8'h37
`define PIDX_DWELL        8'h58
`define PIDX_TARGET_REQ   8'h66
`define PIDX_ENABLE       8'h96
`define PIDX_USER_LO      8'h98
`define PIDX_USER_HI      8'h99
`define BIT_GUARD_RECEIPT 14
`define BIT_SERVO_WINDOW  4
`define BIT_USER_REQUEST  12
`define BIT_TARGET_CHANGE 0
`define BIT_ALARM_EN      1
`define BIT_TARGET_EN     5
`define BIT_CAPTURE_EN    7

`define OD_DEVICE_TYPE    16'h1000
`define OD_ERROR_REG      16'h1001
`define OD_GUARD_TIME     16'h100c
`define OD_LIFE_FACTOR    16'h100d
`define OD_EMCY_COBID     16'h1014
`define OD_IDENTITY       16'h1018
`define OD_SDO_SERVER     16'h1200
`define OD_PARAMS         16'h2000
`define OD_PARAM_SET      16'h2001
`define OD_PARAM_CLEAR    16'h2002
`define OD_PLC            16'h2003
`define OD_CAM_ONE        16'h2004
`define OD_CAM_TWO        16'h2005
`endif

// ### common/canopen_emcy_pkg.sv
package canopen_emcy_pkg;
  typedef enum logic [1:0] {NMT_INIT, NMT_PREOP, NMT_OPER, NMT_STOPPED}
    nmt_state_t;
  typedef enum logic [1:0] {TX_BOOT, TX_GUARD, TX_EMCY} tx_kind_t;
  typedef struct packed {
    logic [15:0] code;
    logic [7:0]  errReg;
    logic [31:0] data;
  } emcy_frame_t;
endpackage

// ### common/emcy_if.sv
`timescale 1ns/1ps
`include "canopen_emcy_defs.svh"
interface emcy_if;
  import canopen_emcy_pkg::*;
  emcy_frame_t                    load [`EMCY_CLASSES];
  logic        [`EMCY_CLASSES-1:0] post;
  logic        [`EMCY_CLASSES-1:0] pending;
  logic                            avail;
  emcy_frame_t                     head;
  logic        [1:0]               headClass;
  logic                            take;
  modport producer(output load, post, take,
                   input pending, avail, head, headClass);
  modport queue(input load, post, take,
                output pending, avail, head, headClass);
endinterface

// ### rtl/emcy_event_queue.sv
`timescale 1ns/1ps
`include "canopen_emcy_defs.svh"
module emcy_event_queue
  import canopen_emcy_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  emcy_if.queue    port
);
  emcy_frame_t                     slot [`EMCY_CLASSES];
  logic        [`EMCY_CLASSES-1:0] pending;
  logic        [1:0]               sel;

  function automatic logic [1:0] firstSet(input logic [3:0] v);
    firstSet = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) begin
        firstSet = i[1:0];
      end
    end
  endfunction

  assign sel            = firstSet(pending);
  assign port.pending   = pending;
  assign port.avail     = |pending;
  assign port.head      = slot[sel];
  assign port.headClass = sel;

  // one slot per class; a post in the take cycle keeps the slot pending
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < `EMCY_CLASSES; i++) begin
      if (rst) begin
        pending[i] <= 1'b0;
        slot[i]    <= '0;
      end else if (port.post[i]) begin
        pending[i] <= 1'b1;
        slot[i]    <= port.load[i];
      end else if (port.take && sel == i[1:0]) begin
        pending[i] <= 1'b0;
      end
    end
  end
endmodule

// ### rtl/canopen_emergency_and_dictionary.sv
`timescale 1ns/1ps
`include "canopen_emcy_defs.svh"
module canopen_emergency_and_dictionary
  import canopen_emcy_pkg::*;
#(
  parameter int          PARAM_COUNT       = `PARAM_COUNT,
  parameter int          DWELL_TICK_CYCLES = `DWELL_TICK_CYCLES,
  parameter logic [31:0] DEVICE_TYPE       = 32'h00000000,
  parameter logic [31:0] VENDOR_ID         = 32'h00000001, // arbitrary
  parameter logic [15:0] GUARD_TIME        = 16'h0000,
  parameter logic [7:0]  LIFE_FACTOR       = 8'h00
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [6:0]  nodeAddressSetting,
  input  wire logic [7:0]  currentAlarmStatus,
  input  wire logic        alarmResetCommand,
  input  wire logic [7:0]  operatingMode,
  input  wire logic [31:0] motorPosition,
  input  wire logic [31:0] targetPosition,
  input  wire logic        firstDigitalInput,
  input  wire logic        rxValid,
  input  wire logic [10:0] rxId,
  input  wire logic        rxRtr,
  input  wire logic [3:0]  rxLen,
  input  wire logic [63:0] rxData,
  input  wire logic        txDone,
  output logic             txValid,
  output logic [10:0]      txId,
  output logic [3:0]       txLen,
  output logic [63:0]      txData,
  output nmt_state_t       nmtState,
  output logic             guardReceipt,
  input  wire logic        odValid,
  input  wire logic        odWrite,
  input  wire logic [15:0] odIndex,
  input  wire logic [7:0]  odSub,
  input  wire logic [2:0]  odLen,
  input  wire logic [31:0] odWData,
  output logic             odBusy,
  output logic             odDone,
  output logic             odAbort,
  output logic [31:0]      odRData,
  output logic             areaReq,
  output logic             areaWrite,
  output logic [1:0]       areaSel,
  output logic [7:0]       areaAddr,
  output logic [2:0]       areaLen,
  output logic [31:0]      areaWData,
  input  wire logic [31:0] areaRData
);
  if (PARAM_COUNT < 154 || PARAM_COUNT > 255 || DWELL_TICK_CYCLES < 1) begin
    $error("parameter area or dwell tick out of range");
  end

  emcy_if q();
  emcy_event_queue u_queue (
    .ref_clk (ref_clk),
    .rst     (rst),
    .port    (q)
  );

  function automatic logic [15:0] alarmCode(input logic [7:0] a);
    case (a)
      `OVERVOLTAGE_ALARM:        alarmCode = `CODE_OVERVOLTAGE;
      `UNDERVOLTAGE_ALARM:       alarmCode = `CODE_UNDERVOLTAGE;
      `OVERCURRENT_ALARM:        alarmCode = `CODE_OVERCURRENT;
      `ENCODER_BREAK_ALARM:      alarmCode = `CODE_ENCODER;
      `MOTOR_OVERTEMP_ALARM:     alarmCode = `CODE_MOTOR_TEMP;
      `DRIVE_OVERTEMP_ALARM:     alarmCode = `CODE_DRIVE_TEMP;
      `AUX_TRIP_ONE_ALARM:       alarmCode = `CODE_AUX_ONE;
      `AUX_TRIP_TWO_ALARM:       alarmCode = `CODE_AUX_TWO;
      `PROGRAM_CHECKSUM_ALARM:   alarmCode = `CODE_CHECKSUM;
      `PARAMETER_CHECKSUM_ALARM: alarmCode = `CODE_CHECKSUM;
      `DEFAULTS_LOADED_ALARM:    alarmCode = `CODE_DEFAULTS;
      8'h00:                     alarmCode = `CODE_NONE;
      default:                   alarmCode = `CODE_GENERIC;
    endcase
  endfunction

  function automatic logic [15:0] applyOp(input logic [15:0] old,
                                          input logic [15:0] val,
                                          input logic [1:0]  op);
    case (op)
      2'h1:    applyOp = old | val;
      2'h2:    applyOp = old & ~val;
      default: applyOp = val;
    endcase
  endfunction

  logic [15:0] params      [PARAM_COUNT];
  logic [15:0] next_params [PARAM_COUNT];
  logic [15:0] enableWord;
  logic        nodeOk;
  logic        alarmEnable;
  logic        targetEnable;
  logic        captureEnable;

  assign enableWord    = params[`PIDX_ENABLE];
  assign nodeOk        = nodeAddressSetting != 7'h00;
  assign alarmEnable   = enableWord[`BIT_ALARM_EN];
  assign targetEnable  = enableWord[`BIT_TARGET_EN];
  assign captureEnable = enableWord[`BIT_CAPTURE_EN];

  // alarm, capture and user events
  logic [7:0] alarmPrev;
  logic       resetSeen;
  logic       alarmChange;
  logic       inputPrev;
  logic       userPrev;
  logic       userRise;
  logic       userSent;
  assign alarmChange = currentAlarmStatus != alarmPrev;
  assign userRise    = params[`PIDX_CONTROL][`BIT_USER_REQUEST] && !userPrev;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      alarmPrev <= 8'h00;
      resetSeen <= 1'b0;
      inputPrev <= 1'b0;
      userPrev  <= 1'b0;
    end else begin
      alarmPrev <= currentAlarmStatus;
      resetSeen <= alarmResetCommand || (resetSeen && !alarmChange);
      inputPrev <= firstDigitalInput;
      userPrev  <= params[`PIDX_CONTROL][`BIT_USER_REQUEST];
    end
  end

  // target reached detection
  logic        armed;
  logic [15:0] reqPrev;
  logic [15:0] dwellTicks;
  logic [31:0] tickCnt;
  logic [31:0] posDiff;
  logic [31:0] posErr;
  logic        inWindow;
  logic        stepArm;
  logic        reqArm;
  logic        reached;
  logic        tick;
  assign posDiff  = motorPosition - targetPosition;
  assign posErr   = posDiff[31] ? (32'h0 - posDiff) : posDiff;
  assign inWindow = posErr <= {16'h0000, params[`PIDX_TOLERANCE]};
  assign stepArm  = targetEnable && operatingMode == `MODE_STEP_TARGET &&
                    params[`PIDX_ENABLE][`BIT_TARGET_CHANGE];
  assign reqArm   = targetEnable && operatingMode == `MODE_REQ_TARGET &&
                    params[`PIDX_TARGET_REQ] != 16'h0000 &&
                    params[`PIDX_TARGET_REQ] != reqPrev;
  assign tick     = tickCnt == DWELL_TICK_CYCLES - 1;
  assign reached  = armed && inWindow &&
                    dwellTicks >= params[`PIDX_DWELL];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      armed      <= 1'b0;
      reqPrev    <= 16'h0000;
      dwellTicks <= 16'h0000;
      tickCnt    <= 32'h0;
    end else begin
      reqPrev <= params[`PIDX_TARGET_REQ];
      tickCnt <= tick ? 32'h0 : tickCnt + 32'h1;
      if (stepArm || reqArm) begin
        armed <= 1'b1;
      end else if (reached || !targetEnable) begin
        armed <= 1'b0;
      end
      if (stepArm || reqArm || !inWindow) begin
        dwellTicks <= 16'h0000;
      end else if (tick && dwellTicks != 16'hffff) begin
        dwellTicks <= dwellTicks + 16'h0001;
      end
    end
  end

  // event posting into the queue
  assign q.post[`CLS_ALARM]   = alarmChange && alarmEnable;
  assign q.post[`CLS_TARGET]  = reached;
  assign q.post[`CLS_CAPTURE] = firstDigitalInput && !inputPrev &&
                                captureEnable;
  assign q.post[`CLS_USER]    = userRise;
  assign q.load[`CLS_ALARM]   = '{code:   resetSeen ? `CODE_NONE :
                                          alarmCode(currentAlarmStatus),
                                  errReg: `ERRREG_ALARM,
                                  data:   {24'h0, currentAlarmStatus}};
  assign q.load[`CLS_TARGET]  = '{code: `CODE_TARGET, errReg: `ERRREG_NONE,
                                  data: motorPosition};
  assign q.load[`CLS_CAPTURE] = '{code: `CODE_CAPTURE, errReg: `ERRREG_NONE,
                                  data: motorPosition};
  assign q.load[`CLS_USER]    = '{code: `CODE_USER, errReg: `ERRREG_NONE,
                                  data: {params[`PIDX_USER_HI],
                                         params[`PIDX_USER_LO]}};

  // network management and transmit arbitration
  logic       nmtHit;
  logic       guardHit;
  logic       guardDue;
  logic       toggle;
  logic       bootDue;
  logic       loadBoot;
  logic       loadGuard;
  logic       loadEmcy;
  logic       sentDone;
  logic [6:0] guardState;
  tx_kind_t   txKind;
  logic [1:0] txClass;
  assign nmtHit    = rxValid && !rxRtr && rxId == {`FUNC_NMT, 7'h00} &&
                     rxLen == 4'h2 && nodeOk &&
                     (rxData[15:8] == 8'h00 ||
                      rxData[15:8] == {1'b0, nodeAddressSetting});
  assign guardHit  = rxValid && rxRtr && nodeOk &&
                     rxId == {`FUNC_GUARD, nodeAddressSetting};
  assign bootDue   = nmtState == NMT_INIT && nodeOk &&
                     !(txValid && txKind == TX_BOOT);
  assign loadBoot  = !txValid && bootDue;
  assign loadGuard = !txValid && !bootDue && guardDue;
  assign loadEmcy  = !txValid && !bootDue && !guardDue && q.avail &&
                     (nmtState == NMT_PREOP || nmtState == NMT_OPER);
  assign q.take    = loadEmcy;
  assign sentDone  = txValid && txDone;
  assign userSent  = sentDone && txKind == TX_EMCY && txClass == `CLS_USER;
  assign guardState = nmtState == NMT_OPER    ? `GUARD_OPER :
                      nmtState == NMT_STOPPED ? `GUARD_STOPPED :
                      nmtState == NMT_PREOP   ? `GUARD_PREOP : 7'h00;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      nmtState <= NMT_INIT;
    end else if (nmtHit) begin
      case (rxData[7:0])
        `NMT_START:      nmtState <= NMT_OPER;
        `NMT_STOP:       nmtState <= NMT_STOPPED;
        `NMT_PREOP:      nmtState <= NMT_PREOP;
        `NMT_RESET_NODE: nmtState <= NMT_INIT;
        `NMT_RESET_COMM: nmtState <= NMT_INIT;
        default:         nmtState <= nmtState;
      endcase
    end else if (sentDone && txKind == TX_BOOT && nmtState == NMT_INIT) begin
      nmtState <= NMT_PREOP;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || (nmtHit && rxData[7] && rxData[0])) begin
      toggle   <= 1'b0;
      guardDue <= 1'b0;
    end else begin
      guardDue <= guardHit || (guardDue && !loadGuard);
      toggle   <= loadGuard ? !toggle : toggle;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txValid <= 1'b0;
      txId    <= 11'h000;
      txLen   <= 4'h0;
      txData  <= 64'h0;
      txKind  <= TX_BOOT;
      txClass <= 2'h0;
    end else if (sentDone) begin
      txValid <= 1'b0;
    end else if (loadBoot || loadGuard) begin
      txValid <= 1'b1;
      txId    <= {`FUNC_GUARD, nodeAddressSetting};
      txLen   <= `BOOT_LEN;
      txData  <= {56'h0, loadGuard ? {toggle, guardState} : 8'h00};
      txKind  <= loadGuard ? TX_GUARD : TX_BOOT;
    end else if (loadEmcy) begin
      txValid <= 1'b1;
      txId    <= {`FUNC_EMCY, nodeAddressSetting};
      txLen   <= `EMCY_LEN;
      txData  <= {q.head.data, 1'b0, nodeAddressSetting, q.head.errReg,
                  q.head.code[7:0], q.head.code[15:8]};
      txKind  <= TX_EMCY;
      txClass <= q.headClass;
    end
  end

  // object dictionary access
  logic        odTake;
  logic        isParam;
  logic        isArea;
  logic        isConst;
  logic        pOk;
  logic        pNextOk;
  logic        paramWrite;
  logic        odReject;
  logic [7:0]  pIdx;
  logic [7:0]  pNext;
  logic [1:0]  pOp;
  logic [31:0] constData;
  logic [31:0] paramData;
  assign odTake  = odValid && !odBusy;
  assign isParam = odIndex >= `OD_PARAMS && odIndex <= `OD_PARAM_CLEAR;
  assign isArea  = odIndex >= `OD_PLC && odIndex <= `OD_CAM_TWO;
  assign isConst = odIndex == `OD_DEVICE_TYPE || odIndex == `OD_ERROR_REG ||
                   odIndex == `OD_GUARD_TIME || odIndex == `OD_LIFE_FACTOR ||
                   odIndex == `OD_EMCY_COBID || odIndex == `OD_IDENTITY ||
                   odIndex == `OD_SDO_SERVER;
  assign pIdx    = odSub - 8'h01;
  assign pNext   = odSub;
  assign pOp     = odIndex[1:0];
  assign pOk     = odSub != 8'h00 && {24'h0, pIdx} < PARAM_COUNT;
  assign pNextOk = {24'h0, pNext} < PARAM_COUNT;
  assign paramWrite = odTake && odWrite && isParam && pOk;
  assign odReject = (isConst && odWrite) ||
                    (isParam && (odSub == 8'h00 ? odWrite : !pOk)) ||
                    (isArea && odSub == 8'h00) ||
                    !(isConst || isParam || isArea);
  assign paramData = pOk ? {pNextOk ? params[pNext] : 16'h0000,
                            params[pIdx]} : 32'(PARAM_COUNT);
  assign constData =
    odIndex == `OD_DEVICE_TYPE ? DEVICE_TYPE :
    odIndex == `OD_ERROR_REG   ? {31'h0, currentAlarmStatus != 8'h00} :
    odIndex == `OD_GUARD_TIME  ? {16'h0, GUARD_TIME} :
    odIndex == `OD_LIFE_FACTOR ? {24'h0, LIFE_FACTOR} :
    odIndex == `OD_EMCY_COBID  ? {21'h0, `FUNC_EMCY, nodeAddressSetting} :
    odIndex == `OD_IDENTITY    ? (odSub == 8'h01 ? VENDOR_ID : 32'h0) :
    odSub == 8'h01 ? {21'h0, `FUNC_SDO_RX, nodeAddressSetting} :
    odSub == 8'h02 ? {21'h0, `FUNC_SDO_TX, nodeAddressSetting} : 32'h2;

  // hardware clears first, then software, then window status and guard receipt win
  always_comb begin
    for (int i = 0; i < PARAM_COUNT; i++) begin
      next_params[i] = params[i];
    end
    if (userSent) begin
      next_params[`PIDX_CONTROL][`BIT_USER_REQUEST] = 1'b0;
    end
    if (stepArm) begin
      next_params[`PIDX_ENABLE][`BIT_TARGET_CHANGE] = 1'b0;
    end
    if (paramWrite) begin
      next_params[pIdx] = applyOp(params[pIdx], odWData[15:0], pOp);
      if (odLen > 3'h2 && pNextOk) begin
        next_params[pNext] = applyOp(params[pNext], odWData[31:16], pOp);
      end
    end
    if (targetEnable) begin
      next_params[`PIDX_CONTROL][`BIT_SERVO_WINDOW] = inWindow;
    end
    if (guardHit) begin
      next_params[`PIDX_GUARD][`BIT_GUARD_RECEIPT] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < PARAM_COUNT; i++) begin
      params[i] <= rst ? 16'h0000 : next_params[i];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      guardReceipt <= 1'b0;
    end else begin
      guardReceipt <= next_params[`PIDX_GUARD][`BIT_GUARD_RECEIPT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      odBusy    <= 1'b0;
      odDone    <= 1'b0;
      odAbort   <= 1'b0;
      odRData   <= 32'h0;
      areaReq   <= 1'b0;
      areaWrite <= 1'b0;
      areaSel   <= 2'h0;
      areaAddr  <= 8'h00;
      areaLen   <= 3'h0;
      areaWData <= 32'h0;
    end else begin
      areaReq <= odTake && isArea && !odReject;
      odBusy  <= odTake && isArea && !odReject;
      odDone  <= (odTake && !(isArea && !odReject)) || odBusy;
      if (odTake) begin
        odAbort   <= odReject;
        odRData   <= odWrite ? 32'h0 : isParam ? paramData : constData;
        areaWrite <= odWrite;
        areaSel   <= odIndex[1:0] - 2'h3;
        areaAddr  <= pIdx;
        areaLen   <= odLen;
        areaWData <= odWData;
      end else if (odBusy) begin
        odRData <= areaWrite ? 32'h0 : areaRData;
      end
    end
  end
endmodule

// ### tb/canopen_emcy_assertions.sv
`timescale 1ns/1ps
module canopen_emcy_checker (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [6:0]  nodeAddressSetting,
  input wire logic        txDone,
  input wire logic        txValid,
  input wire logic [10:0] txId,
  input wire logic [3:0]  txLen,
  input wire logic [63:0] txData,
  input wire logic        odValid,
  input wire logic        odWrite,
  input wire logic [15:0] odIndex,
  input wire logic [7:0]  odSub,
  input wire logic        odBusy,
  input wire logic        odDone,
  input wire logic        odAbort
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  frame_hold_a: assert property (
    txValid && !txDone |=> txValid && $stable(txData) && $stable(txId))
    else $error("frame moved early");
  emcy_len_a: assert property (
    txValid && txId[10:7] == 4'h1 |-> txLen == 4'h8 &&
      txData[31:24] == {1'b0, nodeAddressSetting}) else $error("bad layout");
  emcy_id_a: assert property (
    txValid && txId[10:7] == 4'h1 |-> txId[6:0] == nodeAddressSetting &&
      nodeAddressSetting != 7'h00) else $error("bad id");
  err_reg_a: assert property (
    txValid && txId[10:7] == 4'h1 |-> txData[23:16] == ((txData[7:0] ==
      8'hff && txData[15:8] > 8'h01) ? 8'h00 : 8'h01)) else $error("bad reg");
  ro_abort_a: assert property (
    odValid && !odBusy && odWrite && odIndex[15:12] == 4'h1 |=> odDone &&
      odAbort) else $error("write not refused");
  boot_msg_a: assert property (
    $fell(rst) |-> ##[1:2] txValid && txLen == 4'h1 &&
      txId == {4'he, nodeAddressSetting}) else $error("no boot frame");
  param_answer_a: assert property (
    odValid && !odBusy && odIndex == 16'h2000 |=> odDone && !odBusy)
    else $error("late answer");
  cam_access_a: assert property (
    odValid && !odBusy && odIndex == 16'h2004 && odSub != 8'h00 |=>
      odBusy ##1 odDone) else $error("area answer off");
endmodule
bind canopen_emergency_and_dictionary canopen_emcy_checker chk (.*);

// ### tb/can_master.sv
`timescale 1ns/1ps
module can_master (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        txValid,
  output logic             txDone,
  input  wire logic        areaReq,
  input  wire logic        areaWrite,
  input  wire logic [1:0]  areaSel,
  input  wire logic [7:0]  areaAddr,
  input  wire logic [31:0] areaWData,
  output logic [31:0]      areaRData
);
  logic [31:0] mem [4][256];
  logic [31:0] junk;
  logic [2:0]  dly;
  // outside an area request the data lines flip every cycle
  assign areaRData = areaReq ? mem[areaSel][areaAddr] : junk;
  always_ff @(posedge ref_clk) begin
    junk <= rst ? 32'h5a5aa5a5 : ~junk;
    if (areaReq && areaWrite) begin
      mem[areaSel][areaAddr] <= areaWData;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst || txDone || !txValid) begin
      dly <= 3'h0;
      txDone <= 1'b0;
    end else begin
      dly <= dly + 3'h1;
      txDone <= dly == (slow ? 3'h4 : 3'h0);
    end
  end
endmodule

// ### tb/canopen_emergency_and_dictionary_bench.sv
`timescale 1ns/1ps
module canopen_emergency_and_dictionary_bench
  import canopen_emcy_pkg::*;
;
  localparam logic [6:0] N = 7'h2a;
  logic        ref_clk = 0, rst = 1, alarmResetCommand = 0, slow = 0;
  logic        firstDigitalInput = 0, rxValid = 0, rxRtr = 0, odValid = 0;
  logic        odWrite = 0, txValid, txDone, guardReceipt, odBusy, odDone;
  logic        odAbort, areaReq, areaWrite;
  logic [7:0]  currentAlarmStatus = 0, operatingMode = 0, odSub = 0, areaAddr;
  logic [31:0] motorPosition = 0, targetPosition = 0, odWData = 0, pos;
  logic [31:0] odRData, areaWData, areaRData;
  logic [63:0] rxData = 0, txData;
  logic [15:0] odIndex = 0;
  logic [10:0] rxId = 0, txId;
  logic [3:0]  rxLen = 0, txLen;
  logic [2:0]  odLen = 0, areaLen;
  logic [1:0]  areaSel;
  nmt_state_t  nmtState;
  logic [78:0] txQ [$];
  logic [32:0] odQ [$];
  logic [7:0]  an [11] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                           8'h08, 8'h0a, 8'h0b, 8'h0f};
  logic [15:0] ac [11] = '{16'h3210, 16'h3220, 16'h2340, 16'h7303, 16'h4110,
                           16'h4310, 16'hff00, 16'hff01, 16'h6310, 16'h6310,
                           16'h6320};
  int          errCount = 0, testsRun = 0, i;
  always #10 ref_clk = ~ref_clk;
  canopen_emergency_and_dictionary #(.DWELL_TICK_CYCLES(4)) dut (
    .*, .nodeAddressSetting(N));
  can_master far (.*);
  task automatic err(string m);
    errCount++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic em(logic [15:0] c, logic [7:0] r, logic [31:0] d);
    txQ.push_back({4'h1, N, 4'h8, d, 1'b0, N, r, c[7:0], c[15:8]});
  endtask
  task automatic od(logic w, logic [15:0] x, logic [7:0] s, logic [2:0] l,
                    logic [31:0] d, logic [32:0] e);
    odQ.push_back(e);
    odValid <= 1;
    odWrite <= w;
    odIndex <= x;
    odSub <= s;
    odLen <= l;
    odWData <= d;
    @(posedge ref_clk);
    odValid <= 0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic rx(logic [10:0] x, logic r, logic [7:0] c);
    rxValid <= 1;
    rxId <= x;
    rxRtr <= r;
    rxLen <= r ? 4'h0 : 4'h2;
    rxData <= {48'h0, 1'b0, N, c};
    @(posedge ref_clk);
    rxValid <= 0;
    rxData <= ~{48'h0, 1'b0, N, c};
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic drain;
    int k;
    slow <= 1'($urandom);
    for (k = 0; k < 300 && txQ.size() > 0; k++) @(posedge ref_clk);
    if (txQ.size() > 0) begin
      err("missing frame");
      txQ.delete();
    end
  endtask
  always @(negedge ref_clk) begin
    if (txValid === 1'b1 && txDone === 1'b1) begin
      testsRun++;
      if (txQ.size() == 0 || txQ[0] !== {txId, txLen, txData}) err("frame");
      if (txQ.size() > 0) void'(txQ.pop_front());
    end
    if (odDone === 1'b1) begin
      testsRun++;
      if (odQ.size() == 0 || odAbort !== odQ[0][32] ||
          (!odQ[0][32] && odRData !== odQ[0][31:0])) err("answer");
      if (odQ.size() > 0) void'(odQ.pop_front());
    end
  end
  initial begin
    slow = 1'($urandom(32'hfd4c));
    pos = $urandom;
    repeat (3) @(posedge ref_clk);
    txQ.push_back({4'he, N, 4'h1, 64'h0});
    rst <= 0;
    drain;
    rx(11'h000, 0, 8'h01);
    od(1, 16'h2000, 8'h97, 3'h2, 32'h00a2, 0);
    for (i = 0; i < 11; i++) begin
      em(ac[i], 8'h01, {24'h0, an[i]});
      currentAlarmStatus <= an[i];
      drain;
    end
    alarmResetCommand <= 1;
    @(posedge ref_clk);
    alarmResetCommand <= 0;
    currentAlarmStatus <= 8'h03;
    em(16'h0000, 8'h01, 32'h03);
    drain;
    od(1, 16'h2000, 8'h97, 3'h2, 32'h00a0, 0);
    currentAlarmStatus <= 8'h01;
    $display("alarm test done");
    motorPosition <= pos;
    firstDigitalInput <= 1;
    em(16'hff06, 8'h00, pos);
    drain;
    od(1, 16'h2000, 8'h99, 3'h4, ~pos, 0);
    em(16'hff09, 8'h00, ~pos);
    od(1, 16'h2001, 8'h47, 3'h2, 32'h1000, 0);
    drain;
    od(0, 16'h2000, 8'h47, 3'h4, 0, 0);
    od(1, 16'h2000, 8'h29, 3'h4, 32'hbeef0101, 0);
    od(1, 16'h2001, 8'h29, 3'h2, 32'h30, 0);
    od(1, 16'h2002, 8'h29, 3'h2, 32'h11, 0);
    od(0, 16'h2000, 8'h29, 3'h4, 0, {1'b0, 32'hbeef0120});
    od(0, 16'h2000, 8'h00, 3'h4, 0, 33'h0ff);
    od(1, 16'h1014, 8'h00, 3'h4, pos, {1'b1, 32'h0});
    od(0, 16'h1014, 8'h00, 3'h4, 0, {25'h0, 1'b1, N});
    od(1, 16'h2004, 8'h05, 3'h4, pos, 0);
    od(0, 16'h2004, 8'h05, 3'h4, 0, {1'b0, pos});
    $display("dictionary test done");
    od(1, 16'h2000, 8'h38, 3'h2, 32'h2, 0);
    od(1, 16'h2000, 8'h59, 3'h2, 32'h1, 0);
    targetPosition <= pos + 32'h1;
    operatingMode <= 8'h0d;
    em(16'hff05, 8'h00, pos);
    od(1, 16'h2001, 8'h97, 3'h2, 32'h1, 0);
    drain;
    txQ.push_back({4'he, N, 4'h1, 56'h0, 8'h05});
    rx({4'he, N}, 1, 8'h00);
    drain;
    testsRun++;
    if (guardReceipt !== 1'b1) err("guard flag");
    if (nmtState !== NMT_OPER) err("state");
    $display("guard test done");
    close_out;
  end
  initial begin
    #400000;
    err("watchdog");
    close_out;
  end
endmodule
